// *** pkg/ppsdm_pkg.sv ***
// package: constants, register map and types of the pulse probe speed monitor
package ppsdm_pkg;
	// clock and time base
	localparam int CLK_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int SEC_PER_MIN = 60;
	localparam logic [31:0] RPM_NUM = 32'(64'(SEC_PER_MIN) * 64'(CLK_HZ));
	localparam int MAX_PULSE_HZ = 32_000;
	localparam int MIN_PERIOD_CYCLES = CLK_HZ / MAX_PULSE_HZ;
	localparam int DI_COUNT = 6;
	localparam int PROBE_DI = 3;

	// register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_SRC = 8'h04;
	localparam logic [7:0] ADR_PPR = 8'h08;
	localparam logic [7:0] ADR_MAXT = 8'h0c;
	localparam logic [7:0] ADR_GEAR = 8'h10;
	localparam logic [7:0] ADR_DLY = 8'h14;
	localparam logic [7:0] ADR_DEV = 8'h18;
	localparam logic [7:0] ADR_STAT = 8'h1c;
	localparam logic [7:0] ADR_SPEED = 8'h20;

	// field positions
	localparam int INV_LSB = 0;
	localparam int EDGE_BIT = 4;
	localparam int CFG_LSB = 8;
	localparam int RESP_LSB = 12;
	localparam int SRC_LSB = 0;
	localparam int SPD_SRC_LSB = 16;
	localparam int STAT_ALARM_LSB = 0;
	localparam int STAT_FAULT_LSB = 3;
	localparam int STAT_VALID_BIT = 7;

	// writable bits and reset values
	localparam logic [31:0] CTRL_MASK = 32'h0000_731f;
	localparam logic [31:0] SRC_MASK = 32'h0fff_00ff;
	localparam logic [31:0] HALF_MASK = 32'h0000_ffff;
	localparam logic [31:0] CTRL_RST = 32'h0000_0100;
	localparam logic [31:0] SRC_RST = 32'h0000_0000;
	localparam logic [31:0] PPR_RST = 32'h0000_0001;
	localparam logic [31:0] MAXT_RST = 32'h0000_2710;
	localparam logic [31:0] GEAR_RST = 32'h0000_0100;
	localparam logic [31:0] DLY_RST = 32'h0000_2710;
	localparam logic [31:0] DEV_RST = 32'h0000_0096;

	// selection codes
	localparam logic [7:0] SRC_DI3 = 8'h17;
	localparam logic [11:0] SPD_SRC_PROBE = 12'h24a;
	localparam logic [1:0] CFG_SPEED_LOAD = 2'h2;
	localparam logic [1:0] CFG_OFF = 2'h0;
	localparam logic [2:0] RESP_OFF = 3'h0;
	localparam logic [2:0] RESP_A_LOW = 3'h1;
	localparam logic [2:0] RESP_A_HIGH = 3'h2;
	localparam logic [2:0] RESP_A_BAND = 3'h3;
	localparam logic [2:0] RESP_F_LOW = 3'h4;
	localparam logic [2:0] RESP_F_HIGH = 3'h5;
	localparam logic [2:0] RESP_F_BAND = 3'h6;
	localparam int GEAR_FRAC = 8;

	// measurement state
	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_RUN = 3'b010,
		MS_DIV = 3'b100
	} ppsdm_meas_t;
endpackage

// *** core/ppsdm_divider.sv ***
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module ppsdm_divider #(
	parameter int W = 32
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic [W-1:0] num_i,
	input wire logic [W-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [W-1:0] quo_o
);
	logic [W:0] rem_q;
	logic [W-1:0] quo_q;
	logic [W-1:0] den_q;
	logic [7:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [W:0] rem_sh;
	logic fits;

	generate
		if (W < 2 || W > 64) begin : g_chk
			$error("divider width out of range");
		end
	endgenerate

	// shift in the next numerator bit, subtract when it fits
	assign rem_sh = {rem_q[W-1:0], quo_q[W-1]};
	assign fits = rem_sh >= {1'b0, den_q};

	// iteration; a zero divisor yields all ones, the slowest speed never matters
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rem_q <= '0;
			quo_q <= '0;
			den_q <= '0;
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start_i && !busy_q) begin
				rem_q <= '0;
				quo_q <= num_i;
				den_q <= den_i;
				cnt_q <= 8'(W);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				rem_q <= fits ? rem_sh - {1'b0, den_q} : rem_sh;
				quo_q <= {quo_q[W-2:0], fits};
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign quo_o = quo_q;
endmodule

// *** core/ppsdm_top.sv ***
// pulse probe speed measurement and speed deviation / load failure monitor
// Operation
// - pulse trains up to 32 kHz are evaluated correctly
// - a pulse measuring unit derives load speed from the selected input
// - probe speed is compared with motor speed; excess deviation triggers a response
// - inversion mask resets to zero; bit 3 inverts input 3 into the probe
// - probe source selector resets to 0; value 23 selects input 3
// - edge select resets to 0; 0 times rising, 1 times falling edges
// - pulses per revolution, default 1, scales the speed conversion
// - no new pulse within max measuring time, default 10 s, forces speed zero
// - each qualifying edge restarts the max measuring timeout
// - measured speed times gear factor, default 1, is the readable speed
// - response 0 off, 1-3 alarms low/high/band, 4-6 matching faults
// - a monitor delay, default 10 s, precedes acting on evaluation results
// - speed deviation monitoring runs only when monitor config equals 2
// - monitored speed source resets to 0; 586 selects the probe speed
// - deviations up to allowed deviation, default 150 rpm, are accepted
// - input low longer than delay while motor on raises load failure fault
`timescale 1ns/1ps
module ppsdm_top #(
	parameter int MS_CYCLES = ppsdm_pkg::MS_CYCLES,
	parameter int DI_COUNT = ppsdm_pkg::DI_COUNT
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic [3:0] SEL_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic [DI_COUNT-1:0] DI_I,
	input wire logic signed [15:0] MOTOR_SPEED_ACTUAL_I,
	input wire logic MOTOR_ON_I,
	output logic [15:0] PROBE_SPEED_OUT_O,
	output logic ALARM_SPEED_LOW_O,
	output logic ALARM_SPEED_HIGH_O,
	output logic ALARM_SPEED_OUT_OF_BAND_O,
	output logic FAULT_SPEED_LOW_O,
	output logic FAULT_SPEED_HIGH_O,
	output logic FAULT_SPEED_OUT_OF_BAND_O,
	output logic LOAD_FAILURE_FAULT_O
);
	generate
		if (DI_COUNT <= ppsdm_pkg::PROBE_DI || MS_CYCLES < 1) begin : g_chk
			$error("need digital input 3 and a tick of at least one cycle");
		end
		// divider latency must stay below the shortest pulse period
		if (34 >= ppsdm_pkg::MIN_PERIOD_CYCLES) begin : g_rate
			$error("divider too slow for the highest pulse rate");
		end
	endgenerate

	// byte-lane merge, shared by every writable register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel, input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r & msk;
	endfunction

	logic ack_q;
	logic [31:0] ctrl_q, src_q, ppr_q, maxt_q, gear_q, dly_q, dev_q;
	logic [31:0] tick_cnt_q;
	logic probe_prev_q;
	ppsdm_pkg::ppsdm_meas_t state_q, state_d;
	logic [31:0] per_q;
	logic [31:0] meas_ms_q;
	logic [15:0] probe_speed_q;
	logic [2:0] alarm_q;
	logic [3:0] fault_q;
	logic [31:0] dly_cnt_q [2];
	logic [1:0] trip;
	logic [1:0] cond;
	logic div_busy, div_done;
	logic [31:0] div_quo;

	// one-millisecond enable; a timer's first tick may be partial
	wire tick = tick_cnt_q == 32'(MS_CYCLES - 1);
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) tick_cnt_q <= 32'h0000_0000;
		else tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
	end

	// bus decode: a write lands at the edge where the master samples ack high,
	// so a request withdrawn before its ack never touches a register
	wire wb_req = CYC_I & STB_I & ~ack_q;
	wire wb_wr = CYC_I & STB_I & ack_q & WE_I;
	wire wr_ctrl = wb_wr && ADR_I == ppsdm_pkg::ADR_CTRL;
	wire wr_src = wb_wr && ADR_I == ppsdm_pkg::ADR_SRC;
	wire wr_ppr = wb_wr && ADR_I == ppsdm_pkg::ADR_PPR;
	wire wr_maxt = wb_wr && ADR_I == ppsdm_pkg::ADR_MAXT;
	wire wr_gear = wb_wr && ADR_I == ppsdm_pkg::ADR_GEAR;
	wire wr_dly = wb_wr && ADR_I == ppsdm_pkg::ADR_DLY;
	wire wr_dev = wb_wr && ADR_I == ppsdm_pkg::ADR_DEV;
	wire wr_stat = wb_wr && ADR_I == ppsdm_pkg::ADR_STAT;

	// configuration registers
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_q <= ppsdm_pkg::CTRL_RST;
			src_q <= ppsdm_pkg::SRC_RST;
			ppr_q <= ppsdm_pkg::PPR_RST;
			maxt_q <= ppsdm_pkg::MAXT_RST;
			gear_q <= ppsdm_pkg::GEAR_RST;
			dly_q <= ppsdm_pkg::DLY_RST;
			dev_q <= ppsdm_pkg::DEV_RST;
		end else begin
			if (wr_ctrl) ctrl_q <= merge(ctrl_q, DAT_I, SEL_I, ppsdm_pkg::CTRL_MASK);
			if (wr_src) src_q <= merge(src_q, DAT_I, SEL_I, ppsdm_pkg::SRC_MASK);
			if (wr_ppr) ppr_q <= merge(ppr_q, DAT_I, SEL_I, ppsdm_pkg::HALF_MASK);
			if (wr_maxt) maxt_q <= merge(maxt_q, DAT_I, SEL_I, '1);
			if (wr_gear) gear_q <= merge(gear_q, DAT_I, SEL_I, ppsdm_pkg::HALF_MASK);
			if (wr_dly) dly_q <= merge(dly_q, DAT_I, SEL_I, '1);
			if (wr_dev) dev_q <= merge(dev_q, DAT_I, SEL_I, ppsdm_pkg::HALF_MASK);
		end
	end

	// field views
	wire [3:0] inv_mask = ctrl_q[ppsdm_pkg::INV_LSB +: 4];
	wire edge_sel = ctrl_q[ppsdm_pkg::EDGE_BIT];
	wire [1:0] cfg = ctrl_q[ppsdm_pkg::CFG_LSB +: 2];
	wire [2:0] resp = ctrl_q[ppsdm_pkg::RESP_LSB +: 3];
	wire [7:0] in_src = src_q[ppsdm_pkg::SRC_LSB +: 8];
	wire [11:0] spd_src = src_q[ppsdm_pkg::SPD_SRC_LSB +: 12];

	// probe input: only input 3 can feed the measuring unit
	wire di3_inv = DI_I[ppsdm_pkg::PROBE_DI] ^ inv_mask[ppsdm_pkg::PROBE_DI];
	wire probe_sig = (in_src == ppsdm_pkg::SRC_DI3) ? di3_inv : 1'b0;
	wire qual_edge = edge_sel ? (probe_prev_q & ~probe_sig) : (~probe_prev_q & probe_sig);
	wire in_idle = state_q == ppsdm_pkg::MS_IDLE;
	wire timeout = ~in_idle & ~qual_edge & (meas_ms_q >= maxt_q);
	wire div_start = (state_q == ppsdm_pkg::MS_RUN) & qual_edge;

	// measurement sequence; an edge while dividing is dropped, safe since
	// the divider ends far inside the shortest 32 kHz period
	always_comb begin
		state_d = state_q;
		case (state_q)
			ppsdm_pkg::MS_IDLE: if (qual_edge) state_d = ppsdm_pkg::MS_RUN;
			ppsdm_pkg::MS_RUN: begin
				if (timeout) state_d = ppsdm_pkg::MS_IDLE;
				else if (qual_edge) state_d = ppsdm_pkg::MS_DIV;
			end
			ppsdm_pkg::MS_DIV: begin
				if (timeout) state_d = ppsdm_pkg::MS_IDLE;
				else if (div_done) state_d = ppsdm_pkg::MS_RUN;
			end
			default: state_d = ppsdm_pkg::MS_IDLE;
		endcase
	end

	// period in cycles and timeout in ms, both restart on a qualifying edge
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_q <= ppsdm_pkg::MS_IDLE;
			probe_prev_q <= 1'b0;
			per_q <= 32'h0000_0001;
			meas_ms_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			probe_prev_q <= probe_sig;
			if (qual_edge) per_q <= 32'h0000_0001;
			else if (per_q != 32'hffff_ffff) per_q <= per_q + 32'h0000_0001;
			if (qual_edge || in_idle) meas_ms_q <= 32'h0000_0000;
			else if (tick && meas_ms_q != 32'hffff_ffff) meas_ms_q <= meas_ms_q + 32'h0000_0001;
		end
	end

	// rpm = 60 * f_clk / (period_cycles * ppr), divisor saturates
	wire [15:0] ppr_eff = (ppr_q[15:0] == 16'h0000) ? 16'h0001 : ppr_q[15:0];
	wire [47:0] den_full = {16'h0000, per_q} * {32'h0000_0000, ppr_eff};
	wire [31:0] den = (|den_full[47:32]) ? 32'hffff_ffff : den_full[31:0];

	ppsdm_divider #(
		.W(32)
	) u_div (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.start_i(div_start),
		.num_i(ppsdm_pkg::RPM_NUM),
		.den_i(den),
		.busy_o(div_busy),
		.done_o(div_done),
		.quo_o(div_quo)
	);

	// gear factor is unsigned 8.8 fixed point; results clip at full scale
	wire [15:0] rpm16 = (|div_quo[31:16]) ? 16'hffff : div_quo[15:0];
	wire [31:0] geared = {16'h0000, rpm16} * {16'h0000, gear_q[15:0]};
	wire [15:0] scaled = (|geared[31:24]) ? 16'hffff : geared[23:8];

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) probe_speed_q <= 16'h0000;
		else if (timeout) probe_speed_q <= 16'h0000;
		else if (div_done && state_q == ppsdm_pkg::MS_DIV) probe_speed_q <= scaled;
	end

	// deviation test in 18-bit signed, wide enough for all sums
	wire [15:0] mon_speed = (spd_src == ppsdm_pkg::SPD_SRC_PROBE) ? probe_speed_q : 16'h0000;
	wire signed [17:0] mon_s = $signed({2'b00, mon_speed});
	wire signed [17:0] mot_s = $signed({{2{MOTOR_SPEED_ACTUAL_I[15]}}, MOTOR_SPEED_ACTUAL_I});
	wire signed [17:0] dev_s = $signed({2'b00, dev_q[15:0]});
	wire too_low = mon_s < (mot_s - dev_s);
	wire too_high = mon_s > (mot_s + dev_s);

	// response kind: bit0 low, bit1 high, bit2 band
	wire [2:0] kind = {resp == ppsdm_pkg::RESP_A_BAND || resp == ppsdm_pkg::RESP_F_BAND,
		resp == ppsdm_pkg::RESP_A_HIGH || resp == ppsdm_pkg::RESP_F_HIGH,
		resp == ppsdm_pkg::RESP_A_LOW || resp == ppsdm_pkg::RESP_F_LOW};
	wire is_fault = resp >= ppsdm_pkg::RESP_F_LOW;
	wire mon_en = (cfg == ppsdm_pkg::CFG_SPEED_LOAD) && (|kind);
	wire kind_hit = (kind[0] & too_low) | (kind[1] & too_high) | (kind[2] & (too_low | too_high));
	assign cond[0] = mon_en & kind_hit;
	assign cond[1] = (cfg != ppsdm_pkg::CFG_OFF) & MOTOR_ON_I & ~probe_sig;

	// persistence timers, one per monitored condition
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_dly
			assign trip[gi] = cond[gi] && dly_cnt_q[gi] >= dly_q;
			always_ff @(posedge CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) dly_cnt_q[gi] <= 32'h0000_0000;
				else if (!cond[gi]) dly_cnt_q[gi] <= 32'h0000_0000;
				else if (tick && dly_cnt_q[gi] != 32'hffff_ffff)
					dly_cnt_q[gi] <= dly_cnt_q[gi] + 32'h0000_0001;
			end
		end
	endgenerate

	// alarms follow the tripped state; faults latch until written with one
	wire [3:0] fault_set = {trip[1], (trip[0] & is_fault) ? kind : 3'h0};
	wire [31:0] clr_word = merge(32'h0000_0000, DAT_I, SEL_I, '1);
	wire [3:0] fault_clr = wr_stat ? clr_word[ppsdm_pkg::STAT_FAULT_LSB +: 4] : 4'h0;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			alarm_q <= 3'h0;
			fault_q <= 4'h0;
		end else begin
			alarm_q <= (trip[0] & ~is_fault) ? kind : 3'h0;
			fault_q <= fault_set | (fault_q & ~fault_clr);
		end
	end

	// read data and acknowledge; unmapped reads return zero
	wire [31:0] stat_word = {24'h00_0000, ~in_idle, fault_q, alarm_q};
	wire [31:0] rd_data =
		(ADR_I == ppsdm_pkg::ADR_CTRL) ? ctrl_q :
		(ADR_I == ppsdm_pkg::ADR_SRC) ? src_q :
		(ADR_I == ppsdm_pkg::ADR_PPR) ? ppr_q :
		(ADR_I == ppsdm_pkg::ADR_MAXT) ? maxt_q :
		(ADR_I == ppsdm_pkg::ADR_GEAR) ? gear_q :
		(ADR_I == ppsdm_pkg::ADR_DLY) ? dly_q :
		(ADR_I == ppsdm_pkg::ADR_DEV) ? dev_q :
		(ADR_I == ppsdm_pkg::ADR_STAT) ? stat_word :
		(ADR_I == ppsdm_pkg::ADR_SPEED) ? {16'h0000, probe_speed_q} : 32'h0000_0000;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_q <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req;
			if (wb_req && !WE_I) DAT_O <= rd_data;
		end
	end

	assign ACK_O = ack_q;
	assign PROBE_SPEED_OUT_O = probe_speed_q;
	assign ALARM_SPEED_LOW_O = alarm_q[0];
	assign ALARM_SPEED_HIGH_O = alarm_q[1];
	assign ALARM_SPEED_OUT_OF_BAND_O = alarm_q[2];
	assign FAULT_SPEED_LOW_O = fault_q[0];
	assign FAULT_SPEED_HIGH_O = fault_q[1];
	assign FAULT_SPEED_OUT_OF_BAND_O = fault_q[2];
	assign LOAD_FAILURE_FAULT_O = fault_q[3];

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	edge_pol_a: assert property (qual_edge |-> probe_sig == ~edge_sel)
		else $error("edge taken on wrong polarity");
	// inverted, the taken edge of input 3 runs against the selected direction
	invert_path_a: assert property ((in_src == ppsdm_pkg::SRC_DI3 && inv_mask[3] && qual_edge
		&& $stable(ctrl_q) && $stable(src_q)) |-> DI_I[3] == edge_sel
		&& $past(DI_I[3]) != edge_sel)
		else $error("input 3 not inverted");
	src_route_a: assert property (in_src != ppsdm_pkg::SRC_DI3 |-> !qual_edge || edge_sel)
		else $error("unselected source produced rising edge");
	meas_start_a: assert property (div_start |=> div_busy)
		else $error("divider not started on pulse");
	div_fast_a: assert property (div_start |-> ##[1:34] div_done)
		else $error("speed not ready within a 32 kHz period");
	timeout_zero_a: assert property (timeout |=> probe_speed_q == 16'h0000 && in_idle)
		else $error("timeout did not zero speed");
	timer_restart_a: assert property (qual_edge && !in_idle |=> meas_ms_q == 32'h0)
		else $error("timeout not restarted by edge");
	speed_load_a: assert property (div_done && state_q == ppsdm_pkg::MS_DIV && !timeout
		|=> probe_speed_q == $past(scaled))
		else $error("speed not loaded from divider");
	resp_off_a: assert property (resp == ppsdm_pkg::RESP_OFF |=> alarm_q == 3'h0)
		else $error("alarm with monitoring off");
	cfg_gate_a: assert property (cfg != ppsdm_pkg::CFG_SPEED_LOAD |-> !cond[0])
		else $error("deviation watched outside config 2");
	delay_reset_a: assert property (!cond[0] |=> dly_cnt_q[0] == 32'h0)
		else $error("delay not restarted");
	delay_wait_a: assert property (trip[0] |-> dly_cnt_q[0] >= dly_q)
		else $error("tripped before delay");
	load_fault_a: assert property (trip[1] |=> LOAD_FAILURE_FAULT_O)
		else $error("load failure not latched");
	fault_hold_a: assert property (fault_q[0] && !fault_clr[0] |=> fault_q[0])
		else $error("fault lost without clear");

	alarm_seen_c: cover property ($rose(ALARM_SPEED_OUT_OF_BAND_O));
	speed_meas_c: cover property (div_done && state_q == ppsdm_pkg::MS_DIV);
	timeout_seen_c: cover property (timeout);
	load_fail_c: cover property ($rose(LOAD_FAILURE_FAULT_O));
endmodule

// *** testbench/ppsdm_sensor.sv ***
// proximity sensor model: square wave with set high and low times
`timescale 1ns/1ps
module ppsdm_sensor (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	input wire logic [15:0] hi_cyc_i,
	input wire logic [15:0] lo_cyc_i,
	output logic out_o
);
	logic [15:0] cnt_q;
	logic [15:0] lim;

	// the bench never asks for a period under 625 cycles, i.e. 32 kHz
	assign lim = out_o ? hi_cyc_i : lo_cyc_i;

	// switch output stays low while idle, like an open contact
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 16'h0;
			out_o <= 1'b0;
		end else if (!en_i) begin
			cnt_q <= 16'h0;
			out_o <= 1'b0;
		end else if (cnt_q >= lim - 16'h1) begin
			cnt_q <= 16'h0;
			out_o <= !out_o;
		end else begin
			cnt_q <= cnt_q + 16'h1;
		end
	end
endmodule

// *** testbench/ppsdm_tb_top.sv ***
// self-checking bench of the pulse probe speed monitor
`timescale 1ns/1ps
module ppsdm_tb_top;
	typedef struct packed {
		logic [1:0] cfg;
		logic [2:0] resp;
		logic [15:0] motor;
		logic [5:0] exp;
	} ppsdm_row_t;
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
		logic [7:0] ctl;
		logic [15:0] gear;
		logic [15:0] spd;
		logic rise;
	} ppsdm_edge_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [4:0] noise = 5'h15;
	logic signed [15:0] motor = 16'sh0;
	logic motor_on = 1'b0;
	logic sens_en = 1'b0;
	logic [15:0] hi = 16'h1f4;
	logic [15:0] lo = 16'h5dc;
	logic di3;
	logic di_prev = 1'b0;
	logic [15:0] speed;
	logic [6:0] flags;
	int since_rise = 0;
	int since_fall = 0;
	int cycles = 0;
	int fails = 0;
	int n_tests = 0;
	logic [31:0] q;
	int n;
	ppsdm_row_t rows[11] = '{
		'{2'h2, 3'h1, 16'h1e14, 6'h20}, '{2'h2, 3'h1, 16'h1de2, 6'h00},
		'{2'h2, 3'h2, 16'h1e14, 6'h00}, '{2'h2, 3'h2, 16'h1c84, 6'h10},
		'{2'h2, 3'h3, 16'h1c84, 6'h08}, '{2'h2, 3'h3, 16'h1db0, 6'h00},
		'{2'h2, 3'h4, 16'h1e14, 6'h04}, '{2'h2, 3'h5, 16'h1c84, 6'h02},
		'{2'h2, 3'h6, 16'h1e14, 6'h01}, '{2'h2, 3'h0, 16'h1e14, 6'h00},
		'{2'h1, 3'h1, 16'h1e14, 6'h00}};
	ppsdm_edge_t edges[4] = '{
		'{16'h12c, 16'h145, 8'h00, 16'h80, 16'h5dc0, 1'b1},
		'{16'h1f4, 16'h5dc, 8'h00, 16'h100, 16'h3a98, 1'b1},
		'{16'h1f4, 16'h5dc, 8'h10, 16'h200, 16'h7530, 1'b0},
		'{16'h1f4, 16'h5dc, 8'h18, 16'h80, 16'h1d4c, 1'b1}};
	logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24,
		8'h1c};
	logic [31:0] rv[10] = '{32'h100, 32'h0, 32'h1, 32'h2710, 32'h100, 32'h2710, 32'h96, 32'h0,
		32'h0, 32'h0};

	always #25 clk = ~clk;

	ppsdm_sensor u_ppsdm_sensor (.clk_i(clk), .rst_b_i(rst_b), .en_i(sens_en), .hi_cyc_i(hi),
		.lo_cyc_i(lo), .out_o(di3));

	ppsdm_top #(.MS_CYCLES(20), .DI_COUNT(6)) u_ppsdm_top (.CLK_I(clk), .RST_B_I(rst_b),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel),
		.DAT_O(dat_o), .ACK_O(ack_o), .DI_I({noise[4:3], di3, noise[2:0]}),
		.MOTOR_SPEED_ACTUAL_I(motor), .MOTOR_ON_I(motor_on), .PROBE_SPEED_OUT_O(speed),
		.ALARM_SPEED_LOW_O(flags[6]), .ALARM_SPEED_HIGH_O(flags[5]),
		.ALARM_SPEED_OUT_OF_BAND_O(flags[4]), .FAULT_SPEED_LOW_O(flags[3]),
		.FAULT_SPEED_HIGH_O(flags[2]), .FAULT_SPEED_OUT_OF_BAND_O(flags[1]),
		.LOAD_FAILURE_FAULT_O(flags[0]));

	// edge age counters; unused inputs toggle to prove they are ignored
	always @(posedge clk) begin
		noise <= ~noise;
		di_prev <= di3;
		since_rise <= (di3 && !di_prev) ? 0 : since_rise + 1;
		since_fall <= (!di3 && di_prev) ? 0 : since_fall + 1;
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fails = fails + 1;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fails = fails + 1;
		end
	endtask

	// one classic cycle; held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack_o !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk(32'(k < 20), 32'h1);
	endtask

	task automatic wait_speed(input logic [15:0] exp, input int lim);
		int k;
		k = 0;
		while (speed !== exp && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		wb(1'b1, ppsdm_pkg::ADR_SRC, 32'h024a_0017, q);
		wb(1'b1, ppsdm_pkg::ADR_PPR, 32'h28, q);
		wb(1'b1, ppsdm_pkg::ADR_MAXT, 32'h96, q);
		wb(1'b1, ppsdm_pkg::ADR_DLY, 32'ha, q);
		sens_en <= 1'b1;
		// edge, polarity, gear and rate cases; 48000 rpm from 40 pulses at 625 cycles
		for (int c = 0; c < 4; c++) begin
			hi <= edges[c].hi;
			lo <= edges[c].lo;
			// polarity first, so no result timed on the old edge meets the new gear
			wb(1'b1, ppsdm_pkg::ADR_CTRL, 32'h200 | 32'(edges[c].ctl), q);
			wb(1'b1, ppsdm_pkg::ADR_GEAR, 32'(edges[c].gear), q);
			wait_speed(edges[c].spd, 8000);
			chk(32'(speed), 32'(edges[c].spd));
			n = edges[c].rise ? since_rise : since_fall;
			chk(32'(n < 41), 32'h1);
		end
		// monitor responses at a probe speed of 7500 rpm
		for (int i = 0; i < 11; i++) begin
			wb(1'b1, ppsdm_pkg::ADR_CTRL, (32'(rows[i].resp) << ppsdm_pkg::RESP_LSB) |
				(32'(rows[i].cfg) << ppsdm_pkg::CFG_LSB) | 32'h18, q);
			motor <= rows[i].motor;
			repeat (170) @(posedge clk);
			chk(32'(flags[6:1]), 32'h0);
			repeat (130) @(posedge clk);
			chk(32'(flags[6:1]), 32'(rows[i].exp));
			motor <= 16'sh1d4c;
			repeat (5) @(posedge clk);
			chk(32'(flags[6:1]), 32'(rows[i].exp & 6'h07));
			wb(1'b1, ppsdm_pkg::ADR_STAT, 32'h78, q);
			repeat (3) @(posedge clk);
			chk(32'(flags), 32'h0);
		end
		// steady pulses longer than the max time must keep the speed
		n = 0;
		repeat (4000) begin
			@(posedge clk);
			if (speed !== 16'h1d4c) n++;
		end
		chk(32'(n), 32'h0);
		wb(1'b0, ppsdm_pkg::ADR_SPEED, 32'h0, q);
		chk(q, 32'h1d4c);
		wb(1'b0, ppsdm_pkg::ADR_STAT, 32'h0, q);
		chk(q, 32'h80);
		sens_en <= 1'b0;
		wait_speed(16'h0, 4000);
		chk(32'(since_rise >= 2960 && since_rise <= 3060), 32'h1);
		// load failure: probe input low with the motor on
		wb(1'b1, ppsdm_pkg::ADR_CTRL, 32'h200, q);
		motor_on <= 1'b1;
		repeat (170) @(posedge clk);
		chk(32'(flags[0]), 32'h0);
		repeat (130) @(posedge clk);
		chk(32'(flags[0]), 32'h1);
		motor_on <= 1'b0;
		repeat (5) @(posedge clk);
		chk(32'(flags[0]), 32'h1);
		wb(1'b1, ppsdm_pkg::ADR_STAT, 32'h40, q);
		repeat (2) @(posedge clk);
		chk(32'(flags[0]), 32'h0);
		// second reset in mid-run, then reset values and an unmapped slot
		wb(1'b1, 8'h24, 32'hffff_ffff, q);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		chk({9'h0, flags, speed}, 32'h0);
		rst_b <= 1'b1;
		for (int j = 0; j < 10; j++) begin
			wb(1'b0, ra[j], 32'h0, q);
			chk(q, rv[j]);
		end
		print_verdict();
	end
endmodule
